// ==== include/failsafe_dev_mode_wake_ctrl_consts.vh ====
`ifndef FAILSAFE_DEV_MODE_WAKE_CTRL_CONSTS_VH
`define FAILSAFE_DEV_MODE_WAKE_CTRL_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_MODE_CTRL    4'h0
`define ADDR_HW_CTRL      4'h1
`define ADDR_WAKE_CTRL0   4'h2
`define ADDR_TIMER_CTRL0  4'h3
`define ADDR_DEV_STATUS   4'h4
`define ADDR_CAUSE        4'h5
`define ADDR_WAKE_STAT0   4'h6
`define ADDR_WAKE_STAT2   4'h7

// ****************************************
// Mode requests
// ****************************************
`define MODE_REQ_NORMAL   2'h0
`define MODE_REQ_STOP     2'h1
`define MODE_REQ_SLEEP    2'h2
`define MODE_REQ_SWRESET  2'h3

// ****************************************
// Field positions
// ****************************************
`define HW_OV_RST_BIT     0
`define HW_BUCK_WK_BIT    1
`define HW_AUX_EN_BIT     2
`define HW_FAIL_TEST_STRAP_PIN_BIT    3
`define HW_CFG_BIT2_BIT   4
`define HW_CFG_TWO_BIT    5
`define WC_TIMER_BIT      0
`define WC_PIN_BIT        1
`define WC_CAN_BIT        2
`define CAUSE_OT_BIT      0
`define CAUSE_UV_BIT      1
`define CAUSE_SC_BIT      2
`define CAUSE_OV_BIT      3
`define CAUSE_FO_BIT      4
`define WS0_PIN_BIT       0
`define WS0_TIMER_BIT     1

// ****************************************
// Encodings and reset values
// ****************************************
`define DEVICE_STATE_FIELD_RESET    2'h0
`define DEVICE_STATE_FIELD_RESTART  2'h1
`define DEVICE_STATE_FIELD_SLEEP    2'h2
`define UV_FS_COUNT       2'h3
`define HW_CTRL_RESET     6'h00
`define WAKE_CTRL_RESET   3'h0
`define TIMER_SEL_RESET   3'h0

// ****************************************
// Timing
// ****************************************
`define CLK_HZ            20000000
`define TICK_US           1000
`define FS_MIN_MS         100
`define OT_DWELL_MS       1000
`define IO_SC_MS          10
`define RESTART_MS        10
`define PER0_MS           12'h00A
`define PER1_MS           12'h014
`define PER2_MS           12'h032
`define PER3_MS           12'h064
`define PER4_MS           12'h0C8
`define PER5_MS           12'h3E8
`define PER6_MS           12'h7D0

`endif

// ==== rtl/failsafe_dev_mode_wake_ctrl.v ====
`timescale 1ns/1ps
`include "failsafe_dev_mode_wake_ctrl_consts.vh"

// What this block does
// - Fail-safe entry turns main and aux supplies off and asserts fail output.
// - Fail-safe after one or two watchdog failures per configuration, or severe overtemperature.
// - Fourth consecutive I/O undervoltage event enters fail-safe.
// - I/O overvoltage with reset enable in configuration 2/4 enters fail-safe.
// - I/O short to ground, or long undervoltage beyond detect time, enters fail-safe.
// - Fail-safe entry enables default wake sources and clears wake status 0 and 2.
// - Fail-safe dwell is overtemperature time or minimum time depending on cause.
// - During dwell wake sources are masked but wake events still latch.
// - After dwell, latched or new wake moves fail-safe to restart.
// - Leaving fail-safe does not release the fail output.
// - In fail-safe CAN and wake pin wake; buck-by-wake-pin bit cleared.
// - Cyclic wake is disabled in fail-safe.
// - Device state reads 01 after fail-safe; watchdog count 01 or 10 after watchdog-caused fail-safe.
// - Cause flags: overtemp, undervolt plus short, overvolt; short otherwise zero.
// - Development mode halts watchdog; its failures cause nothing, others still act.
// - Development mode turns CAN on during initialisation.
// - Strap sampled while reset high in init; low throughout plus command latches.
// - Development mode cleared only by power-down or software reset.
// - Strap pull-up enabled only during initialisation.
// - Cyclic wake pulses interrupt in normal and stop at selected period.
// - Wake timer periods 10, 20, 50, 100, 200 ms, 1 s, 2 s.
// - Switch-mode supply on in normal, stop, restart; off in sleep, fail-safe.
module failsafe_dev_mode_wake_ctrl #(
  parameter TICK_CYCLES = (`CLK_HZ / 1000000) * `TICK_US,
  parameter FS_MIN_TICKS = `FS_MIN_MS,
  parameter OT_DWELL_TICKS = `OT_DWELL_MS,
  parameter IO_SC_TICKS = `IO_SC_MS,
  parameter RESTART_TICKS = `RESTART_MS,
  parameter CAN_CH = 4
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire [3:0]        addr,
  input  wire [7:0]        wdata,
  input  wire              wr_stb,
  input  wire              rd_stb,
  output reg  [7:0]        rdata,
  input  wire              watchdog_fail_count_pulse,
  input  wire              severe_overtemp_flag,
  input  wire              io_uv_event,
  input  wire              io_overvolt,
  input  wire              io_short_gnd,
  input  wire              io_below_reset_threshold,
  input  wire              wake_pin,
  input  wire [CAN_CH-1:0] can_wake_event,
  input  wire              fail_test_strap_pin,
  output wire              strap_pullup_en,
  output wire              main_supply_out,
  output wire              aux_supply_out,
  output wire              smps_enable,
  output wire              fail_output,
  output wire              reset_output_n,
  output wire              interrupt_output_n,
  output wire              watchdog_run,
  output wire              can_channels_on,
  output wire              can_channels_wake,
  output wire              wake_pin_wake,
  output wire              buck_mod_by_wake_pin
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_INIT    = 3'h0;
  localparam [2:0] ST_NORMAL  = 3'h1;
  localparam [2:0] ST_STOP    = 3'h2;
  localparam [2:0] ST_SLEEP   = 3'h3;
  localparam [2:0] ST_RESTART = 3'h4;
  localparam [2:0] ST_FS      = 3'h5;

  // Dwell loads cut to the counter width on purpose
  localparam [11:0] FS_MIN_W   = FS_MIN_TICKS[11:0];
  localparam [11:0] OT_DWELL_W = OT_DWELL_TICKS[11:0];
  localparam [11:0] RESTART_W  = RESTART_TICKS[11:0];

  reg  [2:0]        state_reg;
  reg  [15:0]       tick_cnt_reg;
  reg  [11:0]       dwell_cnt_reg;
  reg  [11:0]       sc_cnt_reg;
  reg  [11:0]       cyc_cnt_reg;
  reg  [5:0]        hw_ctrl_reg;
  reg  [2:0]        wake_ctrl_reg;
  reg  [2:0]        timer_sel_reg;
  reg  [1:0]        device_state_field;
  reg  [1:0]        watchdog_fail_count;
  reg  [1:0]        uv_cnt_reg;
  reg               severe_ot_cause;
  reg               io_undervolt_flag;
  reg               io_short_flag;
  reg               io_overvolt_flag;
  reg               fail_out_reg;
  reg  [1:0]        wake_status_reg0;
  reg  [CAN_CH-1:0] wake_status_reg2;
  reg               from_sleep_reg;
  reg               strap_low_reg;
  reg               dev_mode_reg;
  reg               cyc_int_reg;
  reg  [11:0]       period_ms;

  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  wire in_run = (state_reg == ST_NORMAL) || (state_reg == ST_STOP);
  wire in_fs = (state_reg == ST_FS);
  wire watched = in_run || (state_reg == ST_RESTART) || (state_reg == ST_INIT);
  wire cfg_bit2 = hw_ctrl_reg[`HW_CFG_BIT2_BIT];
  wire wr_mode = wr_stb && (addr == `ADDR_MODE_CTRL);

  // ****************************************
  // Failure causes
  // ****************************************
  wire wd_ev = watchdog_fail_count_pulse && watched && !dev_mode_reg;
  wire wd_fs = wd_ev && cfg_bit2 &&
               (!hw_ctrl_reg[`HW_CFG_TWO_BIT] || (watchdog_fail_count != 2'h0));
  wire uv_ev = io_uv_event && watched;
  wire uv_fs = uv_ev && (uv_cnt_reg == `UV_FS_COUNT);
  wire ov_ev = io_overvolt && in_run && hw_ctrl_reg[`HW_OV_RST_BIT];
  wire ov_fs = ov_ev && cfg_bit2;
  wire sc_fs = watched && (io_short_gnd ||
               (io_below_reset_threshold && sc_cnt_reg == IO_SC_TICKS));
  wire ot_fs = severe_overtemp_flag && (watched || (state_reg == ST_SLEEP));
  wire fs_go = !in_fs && (ot_fs || wd_fs || uv_fs || ov_fs || sc_fs);
  wire rs_go = watched && (state_reg != ST_RESTART) && (wd_ev || uv_ev || ov_ev);

  // ****************************************
  // Wake sources
  // ****************************************
  wire wake_any = wake_pin || (|can_wake_event);
  wire sleep_wake = (wake_pin && wake_ctrl_reg[`WC_PIN_BIT]) ||
                    ((|can_wake_event) && wake_ctrl_reg[`WC_CAN_BIT]);
  wire wake_pending = (|wake_status_reg0) || (|wake_status_reg2);
  wire dwell_done = (dwell_cnt_reg == 12'h000);
  wire cyc_hit = in_run && wake_ctrl_reg[`WC_TIMER_BIT] && tick &&
                 (cyc_cnt_reg >= period_ms - 12'h001);
  wire no_sleep_src = !(wake_ctrl_reg[`WC_PIN_BIT] || wake_ctrl_reg[`WC_CAN_BIT]);

  always @*
  begin
    case (timer_sel_reg)
      3'h0:    period_ms = `PER0_MS;
      3'h1:    period_ms = `PER1_MS;
      3'h2:    period_ms = `PER2_MS;
      3'h3:    period_ms = `PER3_MS;
      3'h4:    period_ms = `PER4_MS;
      3'h5:    period_ms = `PER5_MS;
      default: period_ms = `PER6_MS;
    endcase
  end

  // ****************************************
  // Time base and counters
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_cnt_reg <= 16'h0000;
      sc_cnt_reg   <= 12'h000;
      cyc_cnt_reg  <= 12'h000;
      cyc_int_reg  <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (!io_below_reset_threshold || !watched)
        sc_cnt_reg <= 12'h000;
      else if (tick && sc_cnt_reg != IO_SC_TICKS)
        sc_cnt_reg <= sc_cnt_reg + 12'h001;
      if (!in_run || !wake_ctrl_reg[`WC_TIMER_BIT] || cyc_hit)
        cyc_cnt_reg <= 12'h000;
      else if (tick)
        cyc_cnt_reg <= cyc_cnt_reg + 12'h001;
      cyc_int_reg <= cyc_hit;
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg      <= ST_INIT;
      dwell_cnt_reg  <= 12'h000;
      from_sleep_reg <= 1'b0;
      strap_low_reg  <= 1'b1;
      dev_mode_reg   <= 1'b0;
      uv_cnt_reg     <= 2'h0;
    end
    else
    begin
      if (uv_ev)
        uv_cnt_reg <= uv_cnt_reg + 2'h1;
      if (fs_go)
      begin
        state_reg     <= ST_FS;
        uv_cnt_reg    <= 2'h0;
        dwell_cnt_reg <= ot_fs ? OT_DWELL_W : FS_MIN_W;
      end
      else
      begin
        case (state_reg)
          ST_INIT:
          begin
            if (fail_test_strap_pin)
              strap_low_reg <= 1'b0;
            if (wr_stb || rd_stb)
            begin
              state_reg    <= ST_NORMAL;
              dev_mode_reg <= strap_low_reg && !fail_test_strap_pin;
            end
            else if (wd_ev)
              state_reg <= ST_RESTART;
          end
          ST_NORMAL, ST_STOP:
          begin
            if (rs_go)
            begin
              state_reg      <= ST_RESTART;
              from_sleep_reg <= 1'b0;
              dwell_cnt_reg  <= RESTART_W;
            end
            else if (wr_mode)
            begin
              case (wdata[1:0])
                `MODE_REQ_NORMAL: state_reg <= ST_NORMAL;
                `MODE_REQ_STOP:   state_reg <= ST_STOP;
                `MODE_REQ_SLEEP:
                begin
                  // Sleep from stop, with no source or with pending wake, bounces
                  if (state_reg == ST_STOP || no_sleep_src || wake_pending)
                  begin
                    state_reg      <= ST_RESTART;
                    from_sleep_reg <= 1'b0;
                    dwell_cnt_reg  <= RESTART_W;
                  end
                  else
                    state_reg <= ST_SLEEP;
                end
                default:
                begin
                  state_reg     <= ST_INIT;
                  dev_mode_reg  <= 1'b0;
                  strap_low_reg <= 1'b1;
                end
              endcase
            end
          end
          ST_SLEEP:
          begin
            if (sleep_wake)
            begin
              state_reg      <= ST_RESTART;
              from_sleep_reg <= 1'b1;
              dwell_cnt_reg  <= RESTART_W;
            end
          end
          ST_RESTART:
          begin
            if (tick && !dwell_done)
              dwell_cnt_reg <= dwell_cnt_reg - 12'h001;
            if (dwell_done && !io_below_reset_threshold)
              state_reg <= ST_NORMAL;
          end
          ST_FS:
          begin
            if (tick && !dwell_done)
              dwell_cnt_reg <= dwell_cnt_reg - 12'h001;
            if (dwell_done && (wake_pending || wake_any))
            begin
              state_reg      <= ST_RESTART;
              from_sleep_reg <= 1'b0;
              dwell_cnt_reg  <= RESTART_W;
            end
          end
          default: state_reg <= ST_INIT;
        endcase
      end
    end
  end

  // ****************************************
  // Status, cause and wake flags
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      device_state_field  <= `DEVICE_STATE_FIELD_RESET;
      watchdog_fail_count <= 2'h0;
      severe_ot_cause     <= 1'b0;
      io_undervolt_flag   <= 1'b0;
      io_short_flag       <= 1'b0;
      io_overvolt_flag    <= 1'b0;
      fail_out_reg        <= 1'b0;
      wake_status_reg0    <= 2'h0;
      wake_status_reg2    <= {CAN_CH{1'b0}};
    end
    else
    begin
      if (state_reg == ST_RESTART && dwell_done && !io_below_reset_threshold)
        device_state_field <= from_sleep_reg ? `DEVICE_STATE_FIELD_SLEEP : `DEVICE_STATE_FIELD_RESTART;
      else if (wr_stb && addr == `ADDR_DEV_STATUS)
        device_state_field <= `DEVICE_STATE_FIELD_RESET;
      if (wd_ev && watchdog_fail_count != 2'h3)
        watchdog_fail_count <= watchdog_fail_count + 2'h1;
      else if (wr_stb && addr == `ADDR_DEV_STATUS)
        watchdog_fail_count <= 2'h0;
      // Hardware set wins over write-one-to-clear
      if (wr_stb && addr == `ADDR_CAUSE)
      begin
        severe_ot_cause   <= severe_ot_cause & ~wdata[`CAUSE_OT_BIT];
        io_undervolt_flag <= io_undervolt_flag & ~wdata[`CAUSE_UV_BIT];
        io_short_flag     <= io_short_flag & ~wdata[`CAUSE_SC_BIT];
        io_overvolt_flag  <= io_overvolt_flag & ~wdata[`CAUSE_OV_BIT];
        fail_out_reg      <= fail_out_reg & ~wdata[`CAUSE_FO_BIT];
      end
      if (fs_go)
      begin
        fail_out_reg <= 1'b1;
        if (ot_fs)
          severe_ot_cause <= 1'b1;
        if (sc_fs)
        begin
          io_undervolt_flag <= 1'b1;
          io_short_flag     <= 1'b1;
        end
        if (ov_fs)
          io_overvolt_flag <= 1'b1;
      end
      if (uv_ev)
        io_undervolt_flag <= 1'b1;
      if (ov_ev)
        io_overvolt_flag <= 1'b1;
      if (fs_go)
      begin
        wake_status_reg0 <= 2'h0;
        wake_status_reg2 <= {CAN_CH{1'b0}};
      end
      else
      begin
        if (wr_stb && addr == `ADDR_WAKE_STAT0)
          wake_status_reg0 <= wake_status_reg0 & ~wdata[1:0];
        if (wr_stb && addr == `ADDR_WAKE_STAT2)
          wake_status_reg2 <= wake_status_reg2 & ~wdata[CAN_CH-1:0];
        // Wake events are dropped during init, latched elsewhere incl. dwell
        if (state_reg != ST_INIT)
        begin
          if (wake_pin)
            wake_status_reg0[`WS0_PIN_BIT] <= 1'b1;
          if (cyc_hit)
            wake_status_reg0[`WS0_TIMER_BIT] <= 1'b1;
          wake_status_reg2 <= (wr_stb && addr == `ADDR_WAKE_STAT2 ?
                               wake_status_reg2 & ~wdata[CAN_CH-1:0] :
                               wake_status_reg2) | can_wake_event;
        end
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hw_ctrl_reg   <= `HW_CTRL_RESET;
      wake_ctrl_reg <= `WAKE_CTRL_RESET;
      timer_sel_reg <= `TIMER_SEL_RESET;
    end
    else
    begin
      if (wr_stb && addr == `ADDR_HW_CTRL)
        hw_ctrl_reg <= wdata[5:0];
      if (wr_stb && addr == `ADDR_WAKE_CTRL0)
        wake_ctrl_reg <= wdata[2:0];
      if (wr_stb && addr == `ADDR_TIMER_CTRL0)
        timer_sel_reg <= wdata[2:0];
      if (fs_go)
      begin
        hw_ctrl_reg[`HW_BUCK_WK_BIT] <= 1'b0;
        wake_ctrl_reg[`WC_PIN_BIT]   <= 1'b1;
        wake_ctrl_reg[`WC_CAN_BIT]   <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_stb)
    begin
      case (addr)
        `ADDR_MODE_CTRL:   rdata <= {3'h0, dev_mode_reg, 1'b0, state_reg};
        `ADDR_HW_CTRL:     rdata <= {2'h0, hw_ctrl_reg};
        `ADDR_WAKE_CTRL0:  rdata <= {5'h00, wake_ctrl_reg};
        `ADDR_TIMER_CTRL0: rdata <= {5'h00, timer_sel_reg};
        `ADDR_DEV_STATUS:  rdata <= {4'h0, device_state_field, watchdog_fail_count};
        `ADDR_CAUSE:       rdata <= {3'h0, fail_out_reg, io_overvolt_flag, io_short_flag,
                                     io_undervolt_flag, severe_ot_cause};
        `ADDR_WAKE_STAT0:  rdata <= {6'h00, wake_status_reg0};
        `ADDR_WAKE_STAT2:  rdata <= {{(8-CAN_CH){1'b0}}, wake_status_reg2};
        default:           rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign strap_pullup_en      = (state_reg == ST_INIT);
  assign smps_enable          = in_run || (state_reg == ST_RESTART);
  assign main_supply_out      = smps_enable;
  assign aux_supply_out       = hw_ctrl_reg[`HW_AUX_EN_BIT] && !in_fs;
  assign fail_output          = fail_out_reg || hw_ctrl_reg[`HW_FAIL_TEST_STRAP_PIN_BIT];
  assign reset_output_n       = !((state_reg == ST_RESTART) || (state_reg == ST_SLEEP) || in_fs);
  assign interrupt_output_n   = !(cyc_int_reg || (in_run && wake_any));
  assign watchdog_run         = !dev_mode_reg;
  assign can_channels_on      = (state_reg == ST_INIT) ? strap_low_reg : in_run;
  assign can_channels_wake    = in_fs || wake_ctrl_reg[`WC_CAN_BIT];
  assign wake_pin_wake        = in_fs || wake_ctrl_reg[`WC_PIN_BIT];
  assign buck_mod_by_wake_pin = hw_ctrl_reg[`HW_BUCK_WK_BIT];

endmodule // failsafe_dev_mode_wake_ctrl

// ==== verification/failsafe_dev_mode_wake_ctrl_chk.sv ====
`timescale 1ns/1ps
module fs_mode_chk (
  input wire clk,
  input wire nrst,
  input wire wr_stb,
  input wire rd_stb,
  input wire watchdog_fail_count_pulse,
  input wire severe_overtemp_flag,
  input wire io_uv_event,
  input wire io_overvolt,
  input wire io_short_gnd,
  input wire io_below_reset_threshold,
  input wire strap_pullup_en,
  input wire main_supply_out,
  input wire aux_supply_out,
  input wire smps_enable,
  input wire fail_output,
  input wire reset_output_n,
  input wire interrupt_output_n,
  input wire watchdog_run,
  input wire can_channels_wake,
  input wire wake_pin_wake,
  input wire buck_mod_by_wake_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence short_hit;
    main_supply_out && io_short_gnd && !wr_stb;
  endsequence
  sequence fs_entered;
    short_hit ##1 fail_output;
  endsequence
  chk_supply_pair: assert property (main_supply_out == smps_enable
    && (strap_pullup_en || !reset_output_n || smps_enable))
    else $error("switch-mode supply state wrong");
  chk_short_entry: assert property (short_hit |=> fail_output && !main_supply_out && !aux_supply_out)
    else $error("short did not enter fail-safe");
  chk_fs_wake: assert property (short_hit |=> can_channels_wake && wake_pin_wake && !buck_mod_by_wake_pin)
    else $error("fail-safe wake setup wrong");
  chk_ot_entry: assert property (main_supply_out && severe_overtemp_flag |=> fail_output && !main_supply_out)
    else $error("overtemp did not enter fail-safe");
  chk_fs_dwell: assert property (fs_entered |=> !main_supply_out [*8])
    else $error("fail-safe left too early");
  chk_fo_hold: assert property (fail_output && !wr_stb |=> fail_output)
    else $error("fail output dropped");
  chk_dev_wd: assert property (!watchdog_run && main_supply_out && reset_output_n && watchdog_fail_count_pulse && !wr_stb
    && !(severe_overtemp_flag || io_uv_event || io_overvolt || io_short_gnd || io_below_reset_threshold)
    |=> main_supply_out && reset_output_n)
    else $error("watchdog fail acted in development mode");
  chk_init_exit: assert property (strap_pullup_en && (wr_stb || rd_stb) |=> !strap_pullup_en)
    else $error("pull-up kept after init");
  chk_fs_quiet: assert property (!reset_output_n && !$past(reset_output_n) |-> interrupt_output_n)
    else $error("interrupt while held in reset state");
endmodule // fs_mode_chk

bind failsafe_dev_mode_wake_ctrl fs_mode_chk fs_mode_chk_inst (.*);

// ==== verification/mcu_model.sv ====
`timescale 1ns/1ps
`include "failsafe_dev_mode_wake_ctrl_consts.vh"
module mcu_model (
  input  wire        clk,
  output logic [3:0] addr = 4'h0,
  output logic [7:0] wdata = 8'h00,
  output logic       wr_stb = 1'b0,
  output logic       rd_stb = 1'b0
);
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask
  task rd(input [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask
  task cyc_cfg(input [2:0] sel);
    wr(`ADDR_WAKE_CTRL0, 8'h00);
    wr(`ADDR_TIMER_CTRL0, {5'h00, sel});
    wr(`ADDR_WAKE_CTRL0, 8'h01);
  endtask
  task go_sleep;
    wr(`ADDR_WAKE_STAT0, 8'hFF);
    wr(`ADDR_WAKE_STAT2, 8'hFF);
    wr(`ADDR_WAKE_CTRL0, 8'h06);
    wr(`ADDR_MODE_CTRL, {6'h00, `MODE_REQ_SLEEP});
  endtask
endmodule // mcu_model

// ==== verification/test_failsafe_dev_mode_wake_ctrl.sv ====
`timescale 1ns/1ps
`include "failsafe_dev_mode_wake_ctrl_consts.vh"
module test_failsafe_dev_mode_wake_ctrl;
  localparam TICK = 4;
  logic clk = 0, nrst = 0, io_below_reset_threshold = 0, fail_test_strap_pin = 0, rd_pend = 0;
  logic watchdog_fail_count_pulse = 0, severe_overtemp_flag = 0, io_uv_event = 0, io_overvolt = 0, io_short_gnd = 0;
  logic wake_pin = 0;
  logic [3:0] can_wake_event = 4'h0;
  wire [3:0] addr;
  wire [7:0] wdata, rdata;
  wire wr_stb, rd_stb, strap_pullup_en, main_supply_out, aux_supply_out, smps_enable, fail_output;
  wire reset_output_n, interrupt_output_n, watchdog_run, can_channels_on, can_channels_wake;
  wire wake_pin_wake, buck_mod_by_wake_pin;
  logic [31:0] seed = 32'hFB6BBB90, r;
  logic [7:0] exp_q[$];
  int mismatches = 0, num_checks = 0, n;
  int pms[7] = '{`PER0_MS, `PER1_MS, `PER2_MS, `PER3_MS, `PER4_MS, `PER5_MS, `PER6_MS};
  logic [7:0] cause_exp[4] = '{8'h10, 8'h11, 8'h18, 8'h16};
  failsafe_dev_mode_wake_ctrl #(.TICK_CYCLES(TICK), .FS_MIN_TICKS(3), .OT_DWELL_TICKS(5), .IO_SC_TICKS(2),
    .RESTART_TICKS(2)) failsafe_dev_mode_wake_ctrl_inst (.*);
  mcu_model mcu_model_inst (.*);
  always #25 clk = ~clk;
  function logic [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  always @(posedge clk)
  begin
    rd_pend <= rd_stb;
    if (rd_pend)
      check(rdata, exp_q.pop_front());
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tmo;
    mismatches++;
    $display("BAD %0t wait ran out", $time);
    give_verdict;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    exp_q.push_back(e);
    mcu_model_inst.rd(a);
  endtask
  task pulse(input int k);
    @(posedge clk);
    {wake_pin, io_uv_event, io_short_gnd, io_overvolt, severe_overtemp_flag, watchdog_fail_count_pulse} <= 6'h01 << k;
    @(posedge clk);
    {wake_pin, io_uv_event, io_short_gnd, io_overvolt, severe_overtemp_flag, watchdog_fail_count_pulse} <= 6'h00;
  endtask
  task wait_norm;
    n = 0;
    repeat (2) @(posedge clk);
    while (!(reset_output_n && main_supply_out) && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000)
      tmo;
  endtask
  task unmapped;
    r = rnd();
    mcu_model_inst.wr({1'b1, r[2:0]}, r[15:8]);
    rd({1'b1, r[2:0]}, 8'h00);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    check(strap_pullup_en & can_channels_on & reset_output_n, 1);
    nrst <= 1'b1;
    unmapped;
    rd(`ADDR_MODE_CTRL, 8'h11);
    check(watchdog_run, 0);
    mcu_model_inst.wr(`ADDR_HW_CTRL, 8'h10);
    pulse(0);
    rd(`ADDR_MODE_CTRL, 8'h11);
    fail_test_strap_pin <= 1'b1;
    mcu_model_inst.wr(`ADDR_MODE_CTRL, {6'h00, `MODE_REQ_SWRESET});
    @(posedge clk);
    @(negedge clk);
    check(strap_pullup_en & ~can_channels_on, 1);
    unmapped;
    rd(`ADDR_MODE_CTRL, 8'h01);
    check(watchdog_run, 1);
    for (int s = 0; s < 7; s++)
    begin
      mcu_model_inst.cyc_cfg(3'(s));
      for (int p = 0; p < 2; p++)
      begin
        n = 0;
        do
        begin
          @(posedge clk);
          n++;
        end
        while (interrupt_output_n !== 1'b0 && n < 20000);
        if (n >= 20000)
          tmo;
      end
      check(n, pms[s] * TICK);
    end
    mcu_model_inst.wr(`ADDR_WAKE_CTRL0, 8'h06);
    for (int k = 0; k < 4; k++)
    begin
      mcu_model_inst.wr(`ADDR_CAUSE, 8'h1F);
      mcu_model_inst.wr(`ADDR_DEV_STATUS, 8'h00);
      mcu_model_inst.wr(`ADDR_HW_CTRL, 8'h17);
      pulse(5);
      pulse(k);
      @(negedge clk);
      check({fail_output, main_supply_out, aux_supply_out}, 3'b100);
      rd(`ADDR_HW_CTRL, 8'h15);
      rd(`ADDR_CAUSE, cause_exp[k]);
      rd(`ADDR_WAKE_STAT0, 8'h00);
      pulse(5);
      wait_norm;
      rd(`ADDR_DEV_STATUS, (k == 0) ? 8'h05 : 8'h04);
      check(fail_output, 1);
    end
    mcu_model_inst.go_sleep;
    @(negedge clk);
    check(smps_enable, 0);
    pulse(5);
    wait_norm;
    rd(`ADDR_DEV_STATUS, 8'h08);
    mcu_model_inst.wr(`ADDR_CAUSE, 8'h1F);
    for (int i = 0; i < 4; i++)
    begin
      pulse(4);
      if (i < 3)
        wait_norm;
    end
    @(negedge clk);
    check({fail_output, main_supply_out}, 2'b10);
    r = rnd();
    @(posedge clk);
    can_wake_event <= r[3:0] | 4'h1;
    @(posedge clk);
    can_wake_event <= 4'h0;
    wait_norm;
    io_below_reset_threshold <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check({main_supply_out, reset_output_n}, 2'b00);
    rd(`ADDR_CAUSE, 8'h16);
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule // test_failsafe_dev_mode_wake_ctrl
